// ===== logic/ars_pkg.sv
// package of constants for the auto restart sequencer
package ars_pkg;
  // restart mode selector codes
  localparam logic [4:0] MODE_OFF      = 5'h00;
  localparam logic [4:0] MODE_ACK_ONLY = 5'h01;
  localparam logic [4:0] MODE_PWR      = 5'h04;
  localparam logic [4:0] MODE_FLT      = 5'h06;
  localparam logic [4:0] MODE_PWR_MAN  = 5'h0E;
  localparam logic [4:0] MODE_FLT_MAN  = 5'h10;
  localparam logic [4:0] MODE_ALL      = 5'h1A;
  localparam int         MODE_W        = 5;
  // attempt limit width and default
  localparam int         LIMIT_W       = 8;
  localparam logic [7:0] LIMIT_DEFAULT = 8'h03;
  // timer settings count milliseconds
  localparam int         TIME_W        = 20;
  localparam int         CLK_HZ        = 100_000_000;
  localparam int         TICK_MS       = 1;
  localparam int         TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int         PRESC_W       = 17;
  // success settle time: one second after magnetization
  localparam int         SETTLE_S      = 1;
  localparam logic [19:0] SETTLE_MS    = 20'(SETTLE_S * 1000);
  localparam logic [19:0] WAIT_DEFAULT = 20'h003E8; // 1.0 s
  localparam logic [19:0] SUP_DEFAULT  = 20'h0EA60; // 60 s
  localparam logic [19:0] WIN_DEFAULT  = 20'h00000; // 0 s
  // register map, word offsets on the plain port
  localparam logic [3:0] REG_MODE   = 4'h0;
  localparam logic [3:0] REG_LIMIT  = 4'h1;
  localparam logic [3:0] REG_WAIT   = 4'h2;
  localparam logic [3:0] REG_SUP    = 4'h3;
  localparam logic [3:0] REG_WIN    = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;
  localparam logic [3:0] REG_IRQ_ST = 4'h6;
  localparam logic [3:0] REG_IRQ_CL = 4'h7;
  localparam logic [3:0] REG_IRQ_EN = 4'h8;
  localparam int         ADDR_W     = 4;
  localparam int         DATA_W     = 32;
  // interrupt event bits
  localparam int         IRQ_N        = 4;
  localparam int         IRQ_FAIL     = 0;
  localparam int         IRQ_ATTEMPT  = 1;
  localparam int         IRQ_SUCCESS  = 2;
  localparam int         IRQ_ACK      = 3;
  // sequencer states
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_WAIT  = 5'b00010,
    ST_START = 5'b00100,
    ST_SETTLE= 5'b01000,
    ST_ABORT = 5'b10000
  } ars_state_t;
endpackage : ars_pkg

// ===== logic/ars_timer.sv
// millisecond down-counting timer with load and expiry pulse
`timescale 1ns/1ps
module ars_timer
  import ars_pkg::*;
#(
  parameter int W = TIME_W
) (
  input  wire logic         clock,
  input  wire logic         resetn,
  input  wire logic         tick,
  input  wire logic         load,
  input  wire logic         stop,
  input  wire logic [W-1:0] value,
  output logic              running,
  output logic              expired
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         run;
    logic         exp;
  } ars_tmr_t;
  ars_tmr_t s_reg, s_next;

  // load wins over stop; zero length expires on the next tick
  always_comb begin
    s_next     = s_reg;
    s_next.exp = 1'b0;
    if (load) begin
      s_next.cnt = value;
      s_next.run = 1'b1;
    end else if (stop) begin
      s_next.run = 1'b0;
    end else if (s_reg.run && tick) begin
      if (s_reg.cnt == '0) begin
        s_next.run = 1'b0;
        s_next.exp = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt - 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (!resetn) s_reg <= '0;
    else         s_reg <= s_next;
  end

  assign running = s_reg.run;
  assign expired = s_reg.exp;
endmodule : ars_timer

// ===== logic/ars_sequencer.sv
// auto restart sequencer: attempt counting, wait, supervision and reset window
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ps
module ars_sequencer
  import ars_pkg::*;
#(
  // clock cycles per timer tick; a shorter tick speeds up every timer alike
  parameter int TICK_N = TICK_CYCLES
) (
  input  wire logic                      clock,
  input  wire logic                      resetn,
  input  wire logic [ars_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [ars_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                      reg_write,
  input  wire logic                      reg_read,
  output logic      [ars_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                      fault_in,
  input  wire logic                      power_fail_in,
  input  wire logic                      run_command,
  input  wire logic                      ramp_stop_command,
  input  wire logic                      manual_ack,
  input  wire logic                      magnetizing_done_flag,
  output logic                           fault_ack,
  output logic                           start_request,
  output logic                           restart_failed_fault,
  output logic                           irq
);
  import ars_pkg::*;

  // pin synchronisers: three stages, change taken when stages two and three agree
  logic [2:0] sy_fault, sy_pwr, sy_run, sy_stop, sy_mack, sy_mag;
  logic       f_fault, f_pwr, f_run, f_stop, f_mack, f_mag;
  always_ff @(posedge clock) begin
    if (!resetn) begin
      sy_fault <= '0; sy_pwr <= '0; sy_run <= '0;
      sy_stop  <= '0; sy_mack <= '0; sy_mag <= '0;
      f_fault  <= 1'b0; f_pwr <= 1'b0; f_run <= 1'b0;
      f_stop   <= 1'b0; f_mack <= 1'b0; f_mag <= 1'b0;
    end else begin
      sy_fault <= {sy_fault[1:0], fault_in};
      sy_pwr   <= {sy_pwr[1:0], power_fail_in};
      sy_run   <= {sy_run[1:0], run_command};
      sy_stop  <= {sy_stop[1:0], ramp_stop_command};
      sy_mack  <= {sy_mack[1:0], manual_ack};
      sy_mag   <= {sy_mag[1:0], magnetizing_done_flag};
      if (sy_fault[1] == sy_fault[2]) f_fault <= sy_fault[2];
      if (sy_pwr[1] == sy_pwr[2])     f_pwr   <= sy_pwr[2];
      if (sy_run[1] == sy_run[2])     f_run   <= sy_run[2];
      if (sy_stop[1] == sy_stop[2])   f_stop  <= sy_stop[2];
      if (sy_mack[1] == sy_mack[2])   f_mack  <= sy_mack[2];
      if (sy_mag[1] == sy_mag[2])     f_mag   <= sy_mag[2];
    end
  end

  typedef struct packed {
    logic [MODE_W-1:0]  mode;
    logic [LIMIT_W-1:0] limit;
    logic [TIME_W-1:0]  wait_t;
    logic [TIME_W-1:0]  sup_t;
    logic [TIME_W-1:0]  win_t;
    logic [LIMIT_W-1:0] remain;
    logic [LIMIT_W-1:0] succ_cnt;
    logic [IRQ_N-1:0]   irq_st;
    logic [IRQ_N-1:0]   irq_en;
    logic [PRESC_W-1:0] presc;
    logic               tick;
    logic               failed;
    logic               fault_seen;
    logic               stop_seen;
    logic               prev_fault;
    logic               prev_mack;
    logic               ack;
    logic               start;
    logic [DATA_W-1:0]  rdata;
    ars_state_t         state;
  } ars_state_reg_t;
  ars_state_reg_t s_reg, s_next;

  // timer controls
  logic wait_load, wait_exp, sup_load, sup_stop, sup_exp, sup_run;
  logic set_load, set_stop, set_exp, win_load, win_exp, win_run;

  // mode decode
  logic mode_restart, mode_wait, mode_auto_ack, mode_run_ack;
  always_comb begin
    mode_restart = 1'b0;
    mode_wait    = 1'b0;
    mode_auto_ack = 1'b0;
    mode_run_ack = 1'b0;
    case (s_reg.mode)
      MODE_ACK_ONLY: mode_auto_ack = 1'b1;
      MODE_PWR:      begin mode_restart = 1'b1; mode_wait = 1'b1; mode_run_ack = 1'b1; end
      MODE_FLT:      begin mode_restart = 1'b1; mode_wait = 1'b1; mode_run_ack = 1'b1; end
      MODE_PWR_MAN:  mode_restart = 1'b1;
      MODE_FLT_MAN:  mode_restart = 1'b1;
      MODE_ALL:      begin mode_restart = 1'b1; mode_wait = 1'b1; mode_auto_ack = 1'b1; end
      default:       mode_restart = 1'b0;                        // MODE_OFF and others
    endcase
  end

  // effective limit: 0 and 1 both mean one attempt
  logic [LIMIT_W-1:0] eff_limit;
  assign eff_limit = (s_reg.limit == '0) ? LIMIT_W'(1) : s_reg.limit;

  // fault acknowledgement decision
  logic fault_rise, mack_rise, ack_now, succ_evt, reload;
  logic [IRQ_N-1:0] ev;
  always_comb begin
    fault_rise = (f_fault | f_pwr) & ~s_reg.prev_fault;
    mack_rise  = f_mack & ~s_reg.prev_mack;
    ack_now    = 1'b0;
    if (s_reg.fault_seen && !s_reg.failed) begin
      if (mode_auto_ack || (mode_run_ack && f_run) || mack_rise)
        ack_now = 1'b1;
    end
    if (s_reg.failed && mack_rise && s_reg.stop_seen) ack_now = 1'b1;
  end

  // main sequencer
  always_comb begin
    s_next       = s_reg;
    s_next.ack   = 1'b0;
    s_next.start = 1'b0;
    s_next.rdata = '0;
    s_next.prev_fault = f_fault | f_pwr;
    s_next.prev_mack  = f_mack;
    wait_load = 1'b0;
    sup_load  = 1'b0;
    sup_stop  = 1'b0;
    set_load  = 1'b0;
    set_stop  = 1'b0;
    win_load  = 1'b0;
    succ_evt  = 1'b0;
    reload    = 1'b0;
    ev        = '0;
    // millisecond prescaler
    s_next.tick = 1'b0;
    if (s_reg.presc == PRESC_W'(TICK_N - 1)) begin
      s_next.presc = '0;
      s_next.tick  = 1'b1;
    end else begin
      s_next.presc = s_reg.presc + 1'b1;
    end
    if (f_stop) s_next.stop_seen = 1'b1;
    // fault detection starts supervision
    if (fault_rise && s_reg.mode != MODE_OFF) begin
      s_next.fault_seen = 1'b1;
      if (mode_restart && s_reg.sup_t != '0 && !sup_run) sup_load = 1'b1;
      if (s_reg.state == ST_SETTLE || s_reg.state == ST_START) begin
        set_stop     = 1'b1;
        s_next.state = ST_IDLE;
      end
    end
    // acknowledgement
    if (ack_now) begin
      s_next.ack        = 1'b1;
      s_next.fault_seen = 1'b0;
      ev[IRQ_ACK]       = 1'b1;
      if (s_reg.failed) begin
        s_next.failed = 1'b0;
        sup_stop      = 1'b1;
        reload        = 1'b1;
        s_next.state  = ST_IDLE;
      end else if (mode_restart && s_reg.remain != '0) begin
        s_next.remain = s_reg.remain - 1'b1;
        s_next.state  = ST_WAIT;
        if (mode_wait) wait_load = 1'b1;
      end else if (mode_restart) begin
        s_next.failed = 1'b1;
        ev[IRQ_FAIL]  = 1'b1;
      end
    end
    case (s_reg.state)
      ST_IDLE: ;
      ST_WAIT: begin
        if (s_reg.failed || s_next.failed) s_next.state = ST_IDLE;
        else if ((!mode_wait || wait_exp) && f_run) begin
          s_next.start  = 1'b1;
          ev[IRQ_ATTEMPT] = 1'b1;
          s_next.state  = ST_START;
        end
      end
      ST_START: begin
        if (f_mag) begin
          set_load     = 1'b1;
          s_next.state = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (set_exp) begin
          succ_evt     = 1'b1;
          sup_stop     = 1'b1;
          win_load     = 1'b1;
          ev[IRQ_SUCCESS] = 1'b1;
          s_next.state = ST_IDLE;
          if (!win_run) s_next.succ_cnt = LIMIT_W'(1);
          else if (s_reg.succ_cnt >= eff_limit) begin
            s_next.failed = 1'b1;
            ev[IRQ_FAIL]  = 1'b1;
            s_next.state  = ST_ABORT;
          end else s_next.succ_cnt = s_reg.succ_cnt + 1'b1;
        end
      end
      ST_ABORT: if (!s_reg.failed) s_next.state = ST_IDLE;
      default: s_next.state = ST_IDLE;
    endcase
    // supervision expiry fails the restart in any state, also while waiting for acknowledgement
    if (sup_exp && !s_reg.failed) begin
      s_next.failed = 1'b1;
      ev[IRQ_FAIL]  = 1'b1;
      s_next.state  = ST_IDLE;
      // no attempt may begin in the cycle that fails
      s_next.start    = 1'b0;
      ev[IRQ_ATTEMPT] = 1'b0;
    end
    if (win_exp) begin
      reload          = 1'b1;
      s_next.succ_cnt = '0;
    end
    // register writes
    if (reg_write) begin
      case (reg_addr)
        REG_MODE:   begin s_next.mode  = reg_wdata[MODE_W-1:0];  reload = 1'b1; end
        REG_LIMIT:  begin s_next.limit = reg_wdata[LIMIT_W-1:0]; reload = 1'b1; end
        REG_WAIT:   s_next.wait_t = reg_wdata[TIME_W-1:0];
        REG_SUP:    s_next.sup_t  = reg_wdata[TIME_W-1:0];
        REG_WIN:    s_next.win_t  = reg_wdata[TIME_W-1:0];
        REG_IRQ_CL: s_next.irq_st = s_reg.irq_st & ~reg_wdata[IRQ_N-1:0];
        REG_IRQ_EN: s_next.irq_en = reg_wdata[IRQ_N-1:0];
        default: ;
      endcase
    end
    if (reload) begin
      s_next.remain    = (reg_write && reg_addr == REG_LIMIT) ? reg_wdata[LIMIT_W-1:0] : s_reg.limit;
      // a limit of 0 grants one attempt, the same as a limit of 1
      if (s_next.remain == '0) s_next.remain = LIMIT_W'(1);
      s_next.stop_seen = 1'b0;
    end
    s_next.irq_st = s_next.irq_st | ev;                          // set wins over clear
    // register reads, data in the following cycle
    if (reg_read) begin
      case (reg_addr)
        REG_MODE:   s_next.rdata = DATA_W'(s_reg.mode);
        REG_LIMIT:  s_next.rdata = DATA_W'(s_reg.limit);
        REG_WAIT:   s_next.rdata = DATA_W'(s_reg.wait_t);
        REG_SUP:    s_next.rdata = DATA_W'(s_reg.sup_t);
        REG_WIN:    s_next.rdata = DATA_W'(s_reg.win_t);
        REG_STATUS: s_next.rdata = DATA_W'({s_reg.succ_cnt, s_reg.remain, 3'(0), s_reg.state,
                                   win_run, sup_run, s_reg.fault_seen, s_reg.failed});
        REG_IRQ_ST: s_next.rdata = DATA_W'(s_reg.irq_st);
        REG_IRQ_EN: s_next.rdata = DATA_W'(s_reg.irq_en);
        default:    s_next.rdata = '0;
      endcase
    end
  end

  // state register with reset values
  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_reg        <= '0;
      s_reg.mode   <= MODE_OFF;
      s_reg.limit  <= LIMIT_DEFAULT;
      s_reg.remain <= LIMIT_DEFAULT;
      s_reg.wait_t <= WAIT_DEFAULT;
      s_reg.sup_t  <= SUP_DEFAULT;
      s_reg.win_t  <= WIN_DEFAULT;
      s_reg.state  <= ST_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // attempt wait, supervision, settle and counter reset window timers
  ars_timer #(.W(TIME_W)) u_wait (.clock(clock), .resetn(resetn), .tick(s_reg.tick),
    .load(wait_load), .stop(1'b0), .value(s_reg.wait_t), .running(), .expired(wait_exp));
  ars_timer #(.W(TIME_W)) u_sup (.clock(clock), .resetn(resetn), .tick(s_reg.tick),
    .load(sup_load), .stop(sup_stop), .value(s_reg.sup_t), .running(sup_run), .expired(sup_exp));
  ars_timer #(.W(TIME_W)) u_set (.clock(clock), .resetn(resetn), .tick(s_reg.tick),
    .load(set_load), .stop(set_stop), .value(SETTLE_MS), .running(), .expired(set_exp));
  ars_timer #(.W(TIME_W)) u_win (.clock(clock), .resetn(resetn), .tick(s_reg.tick),
    .load(win_load && mode_restart), .stop(1'b0), .value(s_reg.win_t), .running(win_run),
    .expired(win_exp));

  // outputs
  assign reg_rdata            = s_reg.rdata;
  assign fault_ack            = s_reg.ack;
  assign start_request        = s_reg.start;
  assign restart_failed_fault = s_reg.failed;
  assign irq                  = |(s_reg.irq_st & s_reg.irq_en);
endmodule : ars_sequencer

// ===== tb/ars_assertions.sv
// port-level checker of the auto restart sequencer
`timescale 1ns/1ps
module ars_assertions
  import ars_pkg::*;
(
  input wire logic                       clock,
  input wire logic                       resetn,
  input wire logic [ars_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ars_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                       reg_write,
  input wire logic                       reg_read,
  input wire logic [ars_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                       fault_in,
  input wire logic                       power_fail_in,
  input wire logic                       run_command,
  input wire logic                       ramp_stop_command,
  input wire logic                       manual_ack,
  input wire logic                       magnetizing_done_flag,
  input wire logic                       fault_ack,
  input wire logic                       start_request,
  input wire logic                       restart_failed_fault,
  input wire logic                       irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  logic [3:0] mack_age_reg;
  // cycles since manual acknowledge was last high, saturating
  always_ff @(posedge clock) begin
    if (!resetn || manual_ack) begin
      mack_age_reg <= 4'hF;
      if (manual_ack) begin
        mack_age_reg <= 4'h0;
      end
    end else if (mack_age_reg != 4'hF) begin
      mack_age_reg <= mack_age_reg + 4'h1;
    end
  end
  // software masks every interrupt source
  sequence s_en_off;
    reg_write && reg_addr == REG_IRQ_EN && reg_wdata == 32'h0;
  endsequence
  a_ack_one_cycle: assert property (fault_ack |=> !fault_ack)
    else $error("fault acknowledge wider than one cycle");
  a_start_one_cycle: assert property (start_request |=> !start_request)
    else $error("start request wider than one cycle");
  a_no_start_failed: assert property (restart_failed_fault |-> !start_request)
    else $error("start request while restart failed");
  a_start_needs_run: assert property (start_request |-> $past(run_command, 4) || $past(run_command, 5))
    else $error("start request without run command");
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("read data outside read answer cycle");
  a_irq_masked_off: assert property (s_en_off |-> ##3 !irq)
    else $error("interrupt high with all sources masked");
  a_fail_clear_ack: assert property ($fell(restart_failed_fault) |-> mack_age_reg <= 4'h8)
    else $error("restart failed cleared without acknowledge");
  a_reset_quiet: assert property (disable iff (1'b0)
    !resetn |=> !fault_ack && !start_request && !restart_failed_fault && !irq)
    else $error("output active during reset");
endmodule : ars_assertions

bind ars_sequencer ars_assertions chk (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .fault_in(fault_in), .power_fail_in(power_fail_in), .run_command(run_command),
  .ramp_stop_command(ramp_stop_command), .manual_ack(manual_ack),
  .magnetizing_done_flag(magnetizing_done_flag), .fault_ack(fault_ack), .start_request(start_request),
  .restart_failed_fault(restart_failed_fault), .irq(irq));

// ===== tb/ars_motor_model.sv
// model of the motor power stage beside the sequencer
`timescale 1ns/1ps
module ars_motor_model (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic start_request,
  input  wire logic inject_fault,
  output logic      fault_in,
  output logic      magnetizing_done_flag
);
  logic [2:0] mag_cnt_reg;
  // magnetization completes some cycles after a start and drops on a fault
  always_ff @(posedge clock) begin
    if (!resetn || inject_fault) begin
      mag_cnt_reg <= 3'h0;
    end else if (start_request || mag_cnt_reg != 3'h0) begin
      mag_cnt_reg <= (mag_cnt_reg == 3'h7) ? mag_cnt_reg : mag_cnt_reg + 3'h1;
    end
  end
  assign magnetizing_done_flag = (mag_cnt_reg == 3'h7);
  assign fault_in              = inject_fault;
endmodule : ars_motor_model

// ===== tb/ars_sequencer_bench.sv
// self-checking bench of the auto restart sequencer
`timescale 1ns/1ps
module ars_sequencer_bench;
  import ars_pkg::*;
  logic        clock = 1'b0, resetn = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic        power_fail_in = 1'b0, run_command = 1'b0, ramp_stop_command = 1'b0, manual_ack = 1'b0;
  logic        inject = 1'b0, fault_in, magnetizing_done_flag, got;
  logic        fault_ack, start_request, restart_failed_fault, irq;
  int          failures = 0, comparisons = 0;
  // short timer tick so that the settle and window timers fit in the run
  localparam int TICK_N = 4;
  ars_sequencer #(.TICK_N(TICK_N)) dut (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .fault_in(fault_in),
    .power_fail_in(power_fail_in), .run_command(run_command), .ramp_stop_command(ramp_stop_command),
    .manual_ack(manual_ack), .magnetizing_done_flag(magnetizing_done_flag), .fault_ack(fault_ack),
    .start_request(start_request), .restart_failed_fault(restart_failed_fault), .irq(irq));
  ars_motor_model motor (.clock(clock), .resetn(resetn), .start_request(start_request),
    .inject_fault(inject), .fault_in(fault_in), .magnetizing_done_flag(magnetizing_done_flag));
  // 100 MHz clock
  always #5 clock = ~clock;
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick
  task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
    comparisons++;
    if (got_v !== exp_v) begin
      failures++;
      $display("FAIL %0t got %h expected %h", $time, got_v, exp_v);
    end
  endtask : chk
  task automatic rst();
    @(posedge clock);
    resetn <= 1'b0;
    tick(10);
    resetn <= 1'b1;
  endtask : rst
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  // one fault or supply loss event, notes whether it was acknowledged
  task automatic hit(input logic pf, output logic acked);
    acked = 1'b0;
    @(posedge clock);
    power_fail_in <= pf;
    inject        <= !pf;
    repeat (12) begin
      @(negedge clock);
      if (fault_ack === 1'b1) acked = 1'b1;
    end
    @(posedge clock);
    power_fail_in <= 1'b0;
    inject        <= 1'b0;
    tick(8);
    @(negedge clock);
  endtask : hit
  task automatic t_regs();
    logic [31:0] ev [5] = '{32'h0, 32'h3, 32'h3E8, 32'hEA60, 32'h0};
    rst();
    for (int i = 0; i < 5; i++) begin
      rd(4'(i), d);
      chk(d, ev[i]);
    end
    wr(4'hF, 32'h1F);
    rd(4'hF, d);
    chk(d, 32'h0);
    rd(REG_STATUS, d);
    chk(32'({d[19:12], d[8:4]}), 32'h061);
    wr(REG_WAIT, 32'h12345);
    rd(REG_WAIT, d);
    chk(d, 32'h12345);
  endtask : t_regs
  task automatic t_modes();
    logic [4:0] md [7] = '{MODE_OFF, MODE_ACK_ONLY, MODE_PWR, MODE_FLT, MODE_PWR_MAN, MODE_FLT_MAN, MODE_ALL};
    logic [6:0] ack0 = 7'b1000010;
    logic [6:0] ack1 = 7'b1001110;
    logic [6:0] rmode = 7'b1111100;
    logic       e;
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 7; i++) begin
        rst();
        wr(REG_MODE, 32'(md[i]));
        run_command <= r[0];
        tick(6);
        hit(r[0], got);
        e = r[0] ? ack1[i] : ack0[i];
        chk(32'(got), 32'(e));
        rd(REG_STATUS, d);
        chk(32'(d[19:12]), (e && rmode[i]) ? 32'h2 : 32'h3);
      end
    end
    run_command <= 1'b0;
  endtask : t_modes
  task automatic t_limit(input logic [7:0] lim);
    int n;
    n = (lim < 8'h2) ? 1 : int'(lim);
    rst();
    wr(REG_MODE, 32'(MODE_ALL));
    wr(REG_LIMIT, 32'(lim));
    rd(REG_STATUS, d);
    chk(32'(d[19:12]), 32'(n));
    for (int k = 0; k < n; k++) begin
      hit(1'b0, got);
      chk(32'(restart_failed_fault), 32'h0);
    end
    rd(REG_STATUS, d);
    chk(32'(d[19:12]), 32'h0);
    hit(1'b0, got);
    chk(32'(restart_failed_fault), 32'h1);
    @(posedge clock);
    ramp_stop_command <= 1'b1;
    tick(6);
    manual_ack <= 1'b1;
    tick(4);
    manual_ack        <= 1'b0;
    ramp_stop_command <= 1'b0;
    tick(8);
    @(negedge clock);
    chk(32'(restart_failed_fault), 32'h0);
    rd(REG_STATUS, d);
    chk(32'(d[19:12]), 32'(n));
  endtask : t_limit
  task automatic t_irq();
    rst();
    wr(REG_MODE, 32'(MODE_ALL));
    wr(REG_LIMIT, 32'h1);
    wr(REG_IRQ_EN, 32'h1);
    hit(1'b0, got);
    chk(32'(irq), 32'h0);
    hit(1'b0, got);
    chk(32'(irq), 32'h1);
    wr(REG_IRQ_CL, 32'h1);
    tick(2);
    @(negedge clock);
    chk(32'(irq), 32'h0);
    rd(REG_IRQ_ST, d);
    chk(d & 32'h9, 32'h8);
    wr(REG_IRQ_EN, 32'hF);
    tick(2);
    @(negedge clock);
    chk(32'(irq), 32'h1);
    wr(REG_IRQ_EN, 32'h0);
    tick(4);
  endtask : t_irq
  // mode 14: manual acknowledge, start, settle, window reload; a second fault finds no attempt left
  task automatic t_start();
    logic st;
    rst();
    wr(REG_MODE, 32'(MODE_PWR_MAN));
    wr(REG_LIMIT, 32'h1);
    wr(REG_SUP, 32'(SUP_DEFAULT));
    wr(REG_WIN, 32'h64);
    run_command <= 1'b1;
    tick(6);
    for (int k = 0; k < 2; k++) begin
      hit(1'b0, got);
      chk(32'(got), 32'h0);
      st = 1'b0;
      @(posedge clock);
      manual_ack <= 1'b1;
      tick(4);
      manual_ack <= 1'b0;
      repeat (12) begin
        @(negedge clock);
        if (start_request === 1'b1) st = 1'b1;
      end
      chk(32'(st), 32'(k == 0));
      chk(32'(restart_failed_fault), 32'(k));
      if (k == 0) begin
        tick(TICK_N * 1030);
        rd(REG_IRQ_ST, d);
        chk(d & 32'hE, 32'hE);
        rd(REG_STATUS, d);
        chk(32'({d[27:20], d[19:12], d[3:2]}), 32'h402);
      end
    end
    tick(TICK_N * 110);
    rd(REG_STATUS, d);
    chk(32'({d[27:20], d[19:12]}), 32'h001);
    run_command <= 1'b0;
  endtask : t_start
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  // main sequence
  initial begin
    t_regs();
    t_modes();
    for (int l = 0; l < 4; l++) begin
      t_limit(8'(l));
    end
    t_irq();
    t_start();
    end_sim();
  end
  // watchdog against a hung handshake
  initial begin
    tick(30000);
    failures++;
    $display("FAIL %0t watchdog expired", $time);
    end_sim();
  end
endmodule : ars_sequencer_bench
